// ===== rtl/ctg_trigger_gen.sv
// camera trigger generator: source, rate limiter, queue, shapers, outputs
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// [R01] generator mode emits pulses at programmed rate
// [R02] four shapers with width, delay, downscale
// [R03] shaper width counted in microseconds
// [R04] link triggers carry shaper rise/fall events
// [R05] no trigger output until run state active
// [R06] images dropped while acquisition is off
// [R07] reject width longer than trigger period
// [R08] graceful halt finishes pulse, then suppresses
// [R09] async stop truncates pulses immediately
// [R10] external mode uses selected input edges
// [R11] any front input selectable, shareable
// [R12] low-active polarity uses falling edges only
// [R13] rate limits external pulse forwarding
// [R14] lost pulses counted and signalled
// [R15] delay postpones output after trigger edge
// [R16] front output assignable to any shaper
// [R17] software sets very high rate to disable
// [R18] optional queue holds bursts over rate
// [R19] output polarity can be inverted
// [R20] front inputs indexed zero to three
// [R21] queue holds up to 2000 pulses
// [R22] one lost event per discarded pulse
module ctg_trigger_gen
  import ctg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // configuration writes
  input wire ctg_cfg_wr_t cfgWrite,
  output logic writeDone,
  output logic writeError,
  // trigger control
  input wire ctg_src_t triggerSourceMode,
  input wire ctg_run_t runState,
  input wire logic [1:0] inputSelect,
  input wire logic inputPolarity,
  input wire logic queueEnable,
  // front inputs from pins
  input wire logic [NUM_INPUTS-1:0] frontInput,
  // output routing
  input wire logic linkTrigger0Select,
  input wire logic linkTrigger1Select,
  input wire logic [1:0] frontOutSelect0,
  input wire logic [1:0] frontOutSelect1,
  input wire logic [NUM_FRONT_OUT-1:0] outputInvert,
  // trigger outputs
  output logic linkTrigger0,
  output logic linkTrigger1,
  output logic [NUM_FRONT_OUT-1:0] frontOutput,
  // loss reporting
  input wire logic lostCountClear,
  output logic [31:0] lostCount,
  output logic lostEvent,
  output logic [10:0] queueLevel,
  // image gating
  input wire logic acquisitionRunning,
  input wire logic imageValid,
  output logic imageForward,
  output logic imageDropped
);

  logic [31:0] rate_q;
  ctg_shaper_cfg_t shCfg_q [NUM_SHAPERS];
  logic [NUM_INPUTS-1:0] frontSync1_q;
  logic [NUM_INPUTS-1:0] frontSync2_q;
  logic [NUM_INPUTS-1:0] frontPrev_q;
  logic [33:0] acc_q;
  logic credit_q;
  logic [10:0] queue_q;
  logic [31:0] lost_q;
  logic lostEvt_q;
  logic running;
  logic asyncStop;
  logic curIn;
  logic prevIn;
  logic inEdge;
  logic edgeRun;
  logic passDirect;
  logic popQueue;
  logic pushQueue;
  logic lostPulse;
  logic emit;
  logic [33:0] accSum;
  logic widthBad;
  logic rateBad;
  logic cfgBad;
  logic wrDone_q;
  logic wrErr_q;
  ctg_shaper_state_t shState_q [NUM_SHAPERS];
  logic [NUM_SHAPERS-1:0] shLevel;
  logic [NUM_SHAPERS-1:0] shRise_q;
  logic [NUM_SHAPERS-1:0] shFall_q;
  logic link0_q;
  logic link1_q;
  logic [NUM_FRONT_OUT-1:0] front_q;
  logic imgFwd_q;
  logic imgDrop_q;

  // run state decode
  assign running = (runState == RUN_ACTIVE); // see [R05] see [R08]
  assign asyncStop = (runState == RUN_ASYNC_STOP); // see [R09]

  // period check of a configuration write
  always_comb begin
    widthBad = 1'b0;
    rateBad = 1'b0;
    if (cfgWrite.field == FLD_WIDTH) begin
      widthBad = (48'(cfgWrite.data[15:0]) * 48'(rate_q)) > US_PER_S_W; // see [R07]
    end
    for (int i = 0; i < NUM_SHAPERS; i++) begin
      if ((48'(shCfg_q[i].widthUs) * 48'(cfgWrite.data)) > US_PER_S_W) begin
        rateBad = (cfgWrite.field == FLD_RATE); // see [R07]
      end
    end
  end
  assign cfgBad = widthBad | rateBad;

  // configuration storage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rate_q <= RATE_RESET;
      for (int i = 0; i < NUM_SHAPERS; i++) begin
        shCfg_q[i] <= SHAPER_CFG_RESET;
      end
    end else if (cfgWrite.wr && !cfgBad) begin
      case (cfgWrite.field)
        FLD_RATE: rate_q <= cfgWrite.data;
        FLD_WIDTH: shCfg_q[cfgWrite.shaper].widthUs <= cfgWrite.data[15:0]; // see [R03]
        FLD_DELAY: shCfg_q[cfgWrite.shaper].delayUs <= cfgWrite.data[15:0]; // see [R15]
        FLD_DOWNSCALE: shCfg_q[cfgWrite.shaper].downscale <= cfgWrite.data[7:0];
        default: rate_q <= rate_q;
      endcase
    end
  end

  // write answer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrDone_q <= 1'b0;
      wrErr_q <= 1'b0;
    end else begin
      wrDone_q <= cfgWrite.wr & ~cfgBad;
      wrErr_q <= cfgWrite.wr & cfgBad; // see [R07]
    end
  end
  assign writeDone = wrDone_q;
  assign writeError = wrErr_q;

  // front input synchroniser and edge history, sampled through reset so no false edge follows it
  always_ff @(posedge clk) begin
    frontSync1_q <= frontInput;
    frontSync2_q <= frontSync1_q;
    frontPrev_q <= frontSync2_q;
  end

  // selected input edge, polarity chooses direction
  assign curIn = frontSync2_q[inputSelect]; // see [R11] see [R20]
  assign prevIn = frontPrev_q[inputSelect];
  assign inEdge = inputPolarity ? (prevIn & ~curIn) : (~prevIn & curIn); // see [R12]
  assign edgeRun = inEdge & running & (triggerSourceMode == SRC_EXTERNAL); // see [R10]

  // limiter decisions
  assign passDirect = edgeRun & credit_q & (queue_q == '0); // see [R13]
  assign popQueue = running & credit_q & (queue_q != '0);
  assign pushQueue = edgeRun & ~passDirect & queueEnable & (queue_q < QUEUE_DEPTH); // see [R18]
  assign lostPulse = edgeRun & ~passDirect & ~pushQueue; // see [R22]
  always_comb begin
    emit = 1'b0;
    if (running) begin // see [R05]
      if (triggerSourceMode == SRC_GENERATOR) begin
        emit = credit_q; // see [R01]
      end else begin
        emit = passDirect | popQueue; // see [R13]
      end
    end
  end

  // rate accumulator earns one credit per period
  assign accSum = acc_q + 34'(rate_q);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      acc_q <= '0;
      credit_q <= 1'b0;
    end else if (emit) begin
      acc_q <= '0;
      credit_q <= 1'b0;
    end else if (!credit_q) begin
      if (accSum >= CLK_HZ_W) begin
        acc_q <= '0;
        credit_q <= 1'b1; // see [R01] see [R13]
      end else begin
        acc_q <= accSum;
      end
    end
  end

  // pulse queue fill count
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      queue_q <= '0;
    end else if (!running) begin
      queue_q <= '0;
    end else if (pushQueue && !popQueue) begin
      queue_q <= queue_q + 11'd1; // see [R21]
    end else if (popQueue && !pushQueue) begin
      queue_q <= queue_q - 11'd1;
    end
  end
  assign queueLevel = queue_q;

  // lost pulse count, a loss in the cycle of a clear restarts the count at one
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lost_q <= '0;
      lostEvt_q <= 1'b0;
    end else begin
      lostEvt_q <= lostPulse; // see [R22]
      if (lostPulse) begin
        lost_q <= lostCountClear ? 32'h00000001 : ((lost_q == LOST_MAX) ? lost_q : lost_q + 32'h1); // see [R14]
      end else if (lostCountClear) begin
        lost_q <= '0;
      end
    end
  end
  assign lostCount = lost_q;
  assign lostEvent = lostEvt_q;

  // four pulse shapers
  for (genvar g = 0; g < NUM_SHAPERS; g++) begin : gShaper // see [R02]
    logic [6:0] sub_q;
    logic [15:0] us_q;
    logic [7:0] ds_q;
    logic startNow;
    logic usTick;
    assign usTick = (sub_q == US_LAST);
    assign startNow = emit & (ds_q == '0) & (shState_q[g] == SH_IDLE)
                      & (shCfg_q[g].widthUs != '0);

    // downscale phase: only every n-th pulse starts a shape
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        ds_q <= '0;
      end else if (emit) begin
        if (shCfg_q[g].downscale <= 8'h01 || ds_q == shCfg_q[g].downscale - 8'h01) begin
          ds_q <= '0;
        end else begin
          ds_q <= ds_q + 8'h01;
        end
      end
    end

    // delay then high phase, counted in microseconds
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        shState_q[g] <= SH_IDLE;
        sub_q <= '0;
        us_q <= '0;
        shRise_q[g] <= 1'b0;
        shFall_q[g] <= 1'b0;
      end else if (asyncStop) begin
        shState_q[g] <= SH_IDLE; // see [R09]
        shRise_q[g] <= 1'b0;
        shFall_q[g] <= (shState_q[g] == SH_HIGH);
      end else begin
        shRise_q[g] <= 1'b0;
        shFall_q[g] <= 1'b0;
        sub_q <= usTick ? 7'h00 : sub_q + 7'h01;
        case (shState_q[g])
          SH_IDLE: begin
            if (startNow) begin
              sub_q <= '0;
              if (shCfg_q[g].delayUs != '0) begin
                shState_q[g] <= SH_DELAY; // see [R15]
                us_q <= shCfg_q[g].delayUs;
              end else begin
                shState_q[g] <= SH_HIGH;
                us_q <= shCfg_q[g].widthUs; // see [R03]
                shRise_q[g] <= 1'b1;
              end
            end
          end
          SH_DELAY: begin
            if (usTick) begin
              if (us_q == 16'h0001) begin
                shState_q[g] <= SH_HIGH;
                us_q <= shCfg_q[g].widthUs; // see [R03]
                shRise_q[g] <= 1'b1;
              end else begin
                us_q <= us_q - 16'h0001;
              end
            end
          end
          SH_HIGH: begin
            if (usTick) begin
              if (us_q == 16'h0001) begin
                shState_q[g] <= SH_IDLE; // see [R08]
                shFall_q[g] <= 1'b1;
              end else begin
                us_q <= us_q - 16'h0001;
              end
            end
          end
          default: shState_q[g] <= SH_IDLE;
        endcase
      end
    end
    assign shLevel[g] = (shState_q[g] == SH_HIGH);
  end

  // link triggers from shaper 0 events
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      link0_q <= 1'b0;
      link1_q <= 1'b0;
    end else begin
      link0_q <= linkTrigger0Select & shRise_q[0]; // see [R04]
      link1_q <= linkTrigger1Select & shFall_q[0]; // see [R04]
    end
  end
  assign linkTrigger0 = link0_q;
  assign linkTrigger1 = link1_q;

  // front outputs with optional inversion
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      front_q <= '0;
    end else begin
      front_q[0] <= shLevel[frontOutSelect0] ^ outputInvert[0]; // see [R16] see [R19]
      front_q[1] <= shLevel[frontOutSelect1] ^ outputInvert[1]; // see [R19]
    end
  end
  assign frontOutput = front_q;

  // image gating by acquisition state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      imgFwd_q <= 1'b0;
      imgDrop_q <= 1'b0;
    end else begin
      imgFwd_q <= imageValid & acquisitionRunning;
      imgDrop_q <= imageValid & ~acquisitionRunning; // see [R06]
    end
  end
  assign imageForward = imgFwd_q;
  assign imageDropped = imgDrop_q;

  // helper: cycles shaper 0 has been high
  logic [23:0] highCyc_q;
  always_ff @(posedge clk) begin
    if (!reset_n || !shLevel[0]) begin
      highCyc_q <= '0;
    end else begin
      highCyc_q <= highCyc_q + 24'h000001;
    end
  end

  // checks
  sequence s_start0;
    emit && shState_q[0] == SH_IDLE && shCfg_q[0].widthUs != '0 && gShaper[0].ds_q == '0;
  endsequence
  sequence s_busy0;
    shState_q[0] != SH_IDLE;
  endsequence

  property p_stopped_silent;
    @(posedge clk) disable iff (!reset_n) !running && shState_q[0] == SH_IDLE
      |=> shState_q[0] == SH_IDLE && !linkTrigger0;
  endproperty
  a_stopped_silent: assert property (p_stopped_silent) // see [R05]
    else $error("trigger emitted while not running");

  property p_shaper_starts;
    @(posedge clk) disable iff (!reset_n) (s_start0 and !asyncStop) |=> s_busy0;
  endproperty
  a_shaper_starts: assert property (p_shaper_starts) // see [R02]
    else $error("shaper 0 did not start");

  property p_width_exact;
    @(posedge clk) disable iff (!reset_n)
      $fell(shLevel[0]) && !$past(asyncStop) && !$past(cfgWrite.wr)
      |-> $past(highCyc_q) + 24'h000001 == 24'(shCfg_q[0].widthUs) * 24'(CYC_PER_US);
  endproperty
  a_width_exact: assert property (p_width_exact) // see [R03]
    else $error("shaper 0 width wrong");

  property p_link_rise;
    @(posedge clk) disable iff (!reset_n) shRise_q[0] && linkTrigger0Select |=> linkTrigger0;
  endproperty
  a_link_rise: assert property (p_link_rise) // see [R04]
    else $error("link trigger 0 missed rise");

  property p_link_fall;
    @(posedge clk) disable iff (!reset_n) shFall_q[0] && linkTrigger1Select |=> linkTrigger1;
  endproperty
  a_link_fall: assert property (p_link_fall) // see [R04]
    else $error("link trigger 1 missed fall");

  property p_async_cut;
    @(posedge clk) disable iff (!reset_n)
      asyncStop |=> (shLevel == '0) ##1 (frontOutput == $past(outputInvert));
  endproperty
  a_async_cut: assert property (p_async_cut) // see [R09]
    else $error("pulse not truncated");

  property p_reject;
    @(posedge clk) disable iff (!reset_n) cfgWrite.wr && cfgBad |=> writeError && $stable(rate_q);
  endproperty
  a_reject: assert property (p_reject) // see [R07]
    else $error("bad write accepted");

  property p_lost;
    @(posedge clk) disable iff (!reset_n) lostPulse && !lostCountClear && lost_q != LOST_MAX
      |=> lostEvent && lostCount == $past(lost_q) + 32'h1;
  endproperty
  a_lost: assert property (p_lost) // see [R14] see [R22]
    else $error("lost pulse not reported");

  property p_queue_bound;
    @(posedge clk) disable iff (!reset_n) queue_q <= QUEUE_DEPTH;
  endproperty
  a_queue_bound: assert property (p_queue_bound) // see [R21]
    else $error("queue over depth");

  property p_drop_image;
    @(posedge clk) disable iff (!reset_n) imageValid && !acquisitionRunning |=> imageDropped && !imageForward;
  endproperty
  a_drop_image: assert property (p_drop_image) // see [R06]
    else $error("image not dropped");

endmodule // ctg_trigger_gen

`default_nettype wire

// ===== rtl/ctg_pkg.sv
// constants and types of the camera trigger generator
package ctg_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S;
  localparam logic [6:0] US_LAST = 7'(CYC_PER_US - 1);
  localparam logic [33:0] CLK_HZ_W = 34'(CLK_HZ);
  localparam logic [47:0] US_PER_S_W = 48'(US_PER_S);
  // structure
  localparam int unsigned NUM_SHAPERS = 4;
  localparam int unsigned NUM_INPUTS = 4;
  localparam int unsigned NUM_FRONT_OUT = 2;
  localparam logic [10:0] QUEUE_DEPTH = 11'd2000;
  // value after reset and lost count limit
  localparam logic [31:0] RATE_RESET = 32'h0000000A;
  localparam logic [31:0] LOST_MAX = 32'hFFFFFFFF;
  // source of trigger pulses
  typedef enum logic {
    SRC_GENERATOR = 1'h0,
    SRC_EXTERNAL = 1'h1
  } ctg_src_t;
  // run state commands
  typedef enum logic [1:0] {
    RUN_STOPPED = 2'h0,
    RUN_ACTIVE = 2'h1,
    RUN_GRACEFUL_HALT = 2'h3,
    RUN_ASYNC_STOP = 2'h2
  } ctg_run_t;
  // configuration field selector
  typedef enum logic [1:0] {
    FLD_RATE = 2'h0,
    FLD_WIDTH = 2'h1,
    FLD_DELAY = 2'h2,
    FLD_DOWNSCALE = 2'h3
  } ctg_field_t;
  // shaper states
  typedef enum logic [1:0] {
    SH_IDLE = 2'h0,
    SH_DELAY = 2'h1,
    SH_HIGH = 2'h3
  } ctg_shaper_state_t;
  // one configuration write
  typedef struct packed {
    logic wr;
    ctg_field_t field;
    logic [1:0] shaper;
    logic [31:0] data;
  } ctg_cfg_wr_t;
  // per-shaper settings
  typedef struct packed {
    logic [15:0] widthUs;
    logic [15:0] delayUs;
    logic [7:0] downscale;
  } ctg_shaper_cfg_t;
  localparam ctg_shaper_cfg_t SHAPER_CFG_RESET = '0;
endpackage

// ===== tb/ctg_field_model.sv
// trigger sensor and camera model at the far side of the trigger block
`timescale 1ns/100ps
`default_nettype none
module ctg_field_model
  import ctg_pkg::*;
(
  // clock
  input wire logic clk,
  // camera trigger lines
  input wire logic linkTrigger0,
  input wire logic linkTrigger1,
  // sensor pins and camera frames
  output var logic [NUM_INPUTS-1:0] frontInput,
  output var logic imageValid
);
  // pins idle high through pull-ups, frames idle low
  initial begin
    frontInput = '1;
    imageValid = 1'b0;
  end
  // camera sends one frame when exposure ends
  always @(posedge clk) begin
    imageValid <= linkTrigger1;
  end
  // low-going sensor pulse on one pin, length in cycles
  task automatic pulse(input int idx, input int lowCyc);
    @(posedge clk) frontInput[idx] <= 1'b0;
    repeat (lowCyc) @(posedge clk);
    frontInput[idx] <= 1'b1;
  endtask
endmodule // ctg_field_model
`default_nettype wire

// ===== tb/testbench.sv
// self-checking testbench of the camera trigger generator
`timescale 1ns/100ps
`default_nettype none
module testbench
  import ctg_pkg::*;
;
  logic clk, reset_n, writeDone, writeError, inputPolarity, queueEnable;
  logic linkTrigger0, linkTrigger1, lostCountClear, lostEvent;
  logic acquisitionRunning, imageValid, imageForward, imageDropped;
  logic [1:0] inputSelect, frontOutput, outputInvert, prevFo;
  logic [3:0] frontInput;
  logic [31:0] lostCount;
  logic [10:0] queueLevel;
  ctg_cfg_wr_t cfgWrite;
  ctg_src_t srcMode;
  ctg_run_t runState;
  int failures, totalChecks, cyc, nL0, tL0, pL0, tL1, tF0r, tF1r, tF1f, nLost, nFwd, nDrop, n;

  ctg_trigger_gen dut (.clk(clk), .reset_n(reset_n), .cfgWrite(cfgWrite),
    .writeDone(writeDone), .writeError(writeError), .triggerSourceMode(srcMode),
    .runState(runState), .inputSelect(inputSelect), .inputPolarity(inputPolarity),
    .queueEnable(queueEnable), .frontInput(frontInput), .linkTrigger0Select(1'b1),
    .linkTrigger1Select(1'b1), .frontOutSelect0(2'h1), .frontOutSelect1(2'h0),
    .outputInvert(outputInvert), .linkTrigger0(linkTrigger0),
    .linkTrigger1(linkTrigger1), .frontOutput(frontOutput),
    .lostCountClear(lostCountClear), .lostCount(lostCount), .lostEvent(lostEvent),
    .queueLevel(queueLevel), .acquisitionRunning(acquisitionRunning),
    .imageValid(imageValid), .imageForward(imageForward), .imageDropped(imageDropped));
  ctg_field_model fm (.clk(clk), .linkTrigger0(linkTrigger0),
    .linkTrigger1(linkTrigger1), .frontInput(frontInput), .imageValid(imageValid));

  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // event monitor with cycle stamps
  always @(posedge clk) begin
    cyc++;
    if (linkTrigger0 === 1'b1) begin
      nL0++;
      pL0 = tL0;
      tL0 = cyc;
    end
    if (linkTrigger1 === 1'b1) tL1 = cyc;
    if (frontOutput[1] === 1'b1 && prevFo[1] === 1'b0) tF1r = cyc;
    if (frontOutput[1] === 1'b0 && prevFo[1] === 1'b1) tF1f = cyc;
    if (frontOutput[0] === 1'b1 && prevFo[0] === 1'b0) tF0r = cyc;
    nLost += (lostEvent === 1'b1);
    nFwd += (imageForward === 1'b1);
    nDrop += (imageDropped === 1'b1);
    prevFo = frontOutput;
  end
  // comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one configuration write and its answer
  task automatic wrcfg(input ctg_field_t f, input logic [1:0] s, input logic [31:0] d,
                       input logic [1:0] exp);
    @(posedge clk) cfgWrite <= '{wr: 1'b1, field: f, shaper: s, data: d};
    @(posedge clk) cfgWrite.wr <= 1'b0;
    #1 chk({writeError, writeDone}, exp);
  endtask
  // bounded wait for a count of camera triggers
  task automatic waitL0(input int target);
    int k;
    k = 0;
    while (nL0 < target && k < 5000) begin
      @(posedge clk);
      k++;
    end
    #1 chk(nL0 >= target, 1);
  endtask
  task automatic endtest(input string name);
    $display("test %s finished", name);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    print_verdict();
  end
  // test sequence
  initial begin
    reset_n = 1'b0;
    cfgWrite = '0;
    srcMode = SRC_GENERATOR;
    runState = RUN_STOPPED;
    inputSelect = 2'h0;
    inputPolarity = 1'b0;
    queueEnable = 1'b0;
    outputInvert = 2'h0;
    lostCountClear = 1'b0;
    acquisitionRunning = 1'b0;
    prevFo = 2'h0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 chk({linkTrigger0, linkTrigger1, frontOutput, lostEvent}, 32'h0);
    chk(lostCount, 32'h0);
    chk(queueLevel, 32'h0);
    wrcfg(FLD_RATE, 2'h0, 32'd250000, 2'h1);
    wrcfg(FLD_WIDTH, 2'h0, 32'd2, 2'h1);
    wrcfg(FLD_WIDTH, 2'h0, 32'd5, 2'h2);
    wrcfg(FLD_RATE, 2'h0, 32'd600000, 2'h2);
    wrcfg(FLD_WIDTH, 2'h1, 32'd1, 2'h1);
    wrcfg(FLD_DELAY, 2'h1, 32'd1, 2'h1);
    endtest("config");
    // nothing leaves before the run starts
    repeat (1200) @(posedge clk);
    chk(nL0, 0);
    endtest("idle");
    // periodic generator
    @(posedge clk) runState <= RUN_ACTIVE;
    waitL0(3);
    chk((tL0 - pL0) >= 500 && (tL0 - pL0) <= 502, 1);
    repeat (260) @(posedge clk);
    chk(tL1 - tL0, 250);
    chk(tF1f - tF1r, 250);
    chk(tF0r - tF1r, 125);
    chk(tF0r - tL0, 125);
    endtest("generator");
    // graceful halt finishes the pulse
    waitL0(nL0 + 1);
    @(posedge clk) runState <= RUN_GRACEFUL_HALT;
    n = nL0;
    repeat (300) @(posedge clk);
    chk(tL1 - tL0, 250);
    repeat (1200) @(posedge clk);
    chk(nL0, n);
    endtest("graceful");
    // async stop truncates
    @(posedge clk) runState <= RUN_ACTIVE;
    waitL0(nL0 + 1);
    repeat (50) @(posedge clk);
    runState <= RUN_ASYNC_STOP;
    repeat (4) @(posedge clk);
    #1 chk(frontOutput, 2'h0);
    chk((tL1 - tL0) > 50 && (tL1 - tL0) < 60, 1);
    @(posedge clk) outputInvert <= 2'h1;
    repeat (2) @(posedge clk);
    #1 chk(frontOutput, 2'h1);
    @(posedge clk) outputInvert <= 2'h0;
    endtest("async");
    // external falling edges on input two
    @(posedge clk) srcMode <= SRC_EXTERNAL;
    inputSelect <= 2'h2;
    inputPolarity <= 1'b1;
    runState <= RUN_ACTIVE;
    repeat (700) @(posedge clk);
    n = nL0;
    fm.pulse(2, 40);
    repeat (100) @(posedge clk);
    fm.pulse(1, 5);
    repeat (20) @(posedge clk);
    chk(nL0 - n, 1);
    fm.pulse(2, 5);
    repeat (10) @(posedge clk);
    chk(lostCount, 32'h1);
    chk(nLost, 1);
    chk(nL0 - n, 1);
    endtest("external");
    // queued burst, then wait until the released pulse has ended
    @(posedge clk) queueEnable <= 1'b1;
    repeat (600) @(posedge clk);
    n = nL0;
    fm.pulse(2, 5);
    repeat (50) @(posedge clk);
    fm.pulse(2, 5);
    repeat (10) @(posedge clk);
    chk(queueLevel, 32'h1);
    repeat (900) @(posedge clk);
    chk(nL0 - n, 2);
    chk(lostCount, 32'h1);
    @(posedge clk) lostCountClear <= 1'b1;
    @(posedge clk) lostCountClear <= 1'b0;
    #1 chk(lostCount, 32'h0);
    endtest("queue");
    // images only pass during acquisition
    chk(nFwd, 0);
    chk(nDrop > 0, 1);
    @(posedge clk) acquisitionRunning <= 1'b1;
    repeat (600) @(posedge clk);
    fm.pulse(2, 5);
    repeat (600) @(posedge clk);
    chk(nFwd, 1);
    endtest("images");
    // very high rate leaves the limiter open for spaced pulses
    @(posedge clk) queueEnable <= 1'b0;
    wrcfg(FLD_WIDTH, 2'h0, 32'd0, 2'h1);
    wrcfg(FLD_RATE, 2'h0, 32'd1000000, 2'h1);
    n = nLost;
    fm.pulse(2, 5);
    repeat (150) @(posedge clk);
    fm.pulse(2, 5);
    repeat (20) @(posedge clk);
    chk(nLost - n, 0);
    chk(lostCount, 32'h0);
    chk(queueLevel, 32'h0);
    endtest("open rate");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
